// ===== rtl/ccp_clock_ctrl.sv
// System clock selection and power-mode controller top
`timescale 1ns/1ps
`default_nettype none
module ccp_clock_ctrl #(
  parameter int FAST_DIV   = ccp_pkg::FAST_TICK_DIV,
  parameter int SLOW_DIV   = ccp_pkg::SLOW_TICK_DIV,
  parameter int FAST_SETTLE = ccp_pkg::FAST_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // CPU core power control
  input  wire logic        HALT,
  input  wire logic        WAKE,
  output logic             CPU_RUN,
  // Clock ticks to CPU and peripherals
  output logic             SYS_TICK,
  output logic             FAST_TICK,
  output logic             SUB_TICK,
  output logic             SLOW_OSC_TICK
);
  localparam int DIV_W = ccp_pkg::DIV_BITS;

  // Registers
  logic [2:0]        sel_r;
  logic              hs_keep_r;
  logic              ls_keep_r;
  logic              fosc_en_r;
  logic              wdt_en_r;
  ccp_pkg::ccp_mode_t mode_r;
  logic [DIV_W-1:0]  div_cnt_r;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic              cpu_run_r;
  logic              sys_tick_r;
  logic              fast_tick_r;
  logic              sub_tick_r;
  logic              slow_rc_osc_tick_r;

  // Bus request decode
  logic       req;
  logic       wr_go;
  logic       lane0;
  logic [7:0] src_tick;
  logic       sw_tick;
  logic [2:0] sel_act;
  logic       sw_busy;
  logic       sel_fast;
  logic       sys_on;
  logic       sub_on;

  ccp_osc_if fast_osc ();
  ccp_osc_if slow_osc ();

  // Fast clock from the fast RC osc, sub clock from the slow one
  ccp_rc_osc #(
    .TICK_DIV   (FAST_DIV),
    .SETTLE_CYC (FAST_SETTLE)
  ) u_fast (
    .clk  (CLK),
    .srst (SRST),
    .osc  (fast_osc.src)
  );

  ccp_rc_osc #(
    .TICK_DIV   (SLOW_DIV),
    .SETTLE_CYC (ccp_pkg::SLOW_SETTLE_CYC)
  ) u_slow (
    .clk  (CLK),
    .srst (SRST),
    .osc  (slow_osc.src)
  );

  assign req   = AVS_READ || AVS_WRITE;
  assign wr_go = AVS_WRITE && !wait_r;
  assign lane0 = AVS_BYTEENABLE[0];
  assign sel_fast = (sel_act != ccp_pkg::SEL_SUB);

  // Power-of-two tick on the all-ones prescaler count
  function automatic logic div_hit(input logic [DIV_W-1:0] cnt, input int n);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((1 << n) - 1);
    return (cnt & mask) == mask;
  endfunction

  always_ff @(posedge CLK) begin
    if (SRST || !fast_osc.en)
      div_cnt_r <= '0;
    else if (fast_osc.tick)
      div_cnt_r <= div_cnt_r + 1'b1;
  end

  // Codes 0..6 give fast divided by 2^n, code 7 gives sub clock
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_div
      assign src_tick[gi] = fast_osc.tick && div_hit(div_cnt_r, gi);
    end
  endgenerate
  assign src_tick[ccp_pkg::SEL_SUB] = slow_osc.tick;

  ccp_clk_switch u_switch (
    .clk      (CLK),
    .srst     (SRST),
    .sel_req  (sel_r),
    .src_tick (src_tick),
    .sys_tick (sw_tick),
    .sel_act  (sel_act),
    .busy     (sw_busy)
  );

  // Fast osc: forced on while it feeds the CPU or a switch toward it
  // In SLOW mode it follows its enable bit
  always_comb begin
    case (mode_r)
      ccp_pkg::MODE_RUN:       fast_osc.en = sel_fast || sel_r != ccp_pkg::SEL_SUB
                                             || fosc_en_r;
      ccp_pkg::MODE_IDLE_BOTH: fast_osc.en = 1'b1;
      ccp_pkg::MODE_IDLE_HIGH: fast_osc.en = 1'b1;
      default:                 fast_osc.en = 1'b0;
    endcase
  end

  // Slow osc runs always except SLEEP without watchdog
  assign slow_osc.en = !(mode_r == ccp_pkg::MODE_SLEEP && !wdt_en_r);

  // Peripheral sub clock and system clock gating per mode
  always_comb begin
    case (mode_r)
      ccp_pkg::MODE_RUN: begin
        sys_on = 1'b1;
        sub_on = 1'b1;
      end
      ccp_pkg::MODE_IDLE_LOW: begin
        sys_on = !sel_fast;
        sub_on = 1'b1;
      end
      ccp_pkg::MODE_IDLE_BOTH: begin
        sys_on = 1'b1;
        sub_on = 1'b1;
      end
      ccp_pkg::MODE_IDLE_HIGH: begin
        sys_on = sel_fast;
        sub_on = 1'b0;
      end
      default: begin
        sys_on = 1'b0;
        sub_on = 1'b0;
      end
    endcase
  end

  // Halt picks the off-mode from the keep bits; keep bits unused in run
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_r <= ccp_pkg::MODE_RUN;
    end else if (mode_r == ccp_pkg::MODE_RUN) begin
      if (HALT) begin
        case ({hs_keep_r, ls_keep_r})
          2'h0:    mode_r <= ccp_pkg::MODE_SLEEP;
          2'h1:    mode_r <= ccp_pkg::MODE_IDLE_LOW;
          2'h3:    mode_r <= ccp_pkg::MODE_IDLE_BOTH;
          default: mode_r <= ccp_pkg::MODE_IDLE_HIGH;
        endcase
      end
    end else if (WAKE) begin
      mode_r <= ccp_pkg::MODE_RUN;
    end
  end

  // Clock outputs, registered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cpu_run_r   <= 1'b0;
      sys_tick_r  <= 1'b0;
      fast_tick_r <= 1'b0;
      sub_tick_r  <= 1'b0;
      slow_rc_osc_tick_r <= 1'b0;
    end else begin
      cpu_run_r   <= (mode_r == ccp_pkg::MODE_RUN);
      sys_tick_r  <= sw_tick && sys_on;
      fast_tick_r <= fast_osc.tick;
      sub_tick_r  <= slow_osc.tick && sub_on;
      slow_rc_osc_tick_r <= slow_osc.tick;
    end
  end

  // Software registers; written only in the accepting cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sel_r     <= ccp_pkg::SEL_RESET;
      hs_keep_r <= 1'b0;
      ls_keep_r <= 1'b0;
      fosc_en_r <= ccp_pkg::FOSC_EN_RST;
      wdt_en_r  <= 1'b0;
    end else if (wr_go && lane0) begin
      case (AVS_ADDRESS)
        ccp_pkg::OFS_SCC: begin
          sel_r     <= AVS_WRITEDATA[ccp_pkg::SCC_SEL_LSB +: 3];
          hs_keep_r <= AVS_WRITEDATA[ccp_pkg::SCC_HS_KEEP];
          ls_keep_r <= AVS_WRITEDATA[ccp_pkg::SCC_LS_KEEP];
        end
        ccp_pkg::OFS_FOSC: fosc_en_r <= AVS_WRITEDATA[ccp_pkg::FOSC_EN_BIT];
        ccp_pkg::OFS_CTRL: wdt_en_r  <= AVS_WRITEDATA[ccp_pkg::CTRL_WDT_BIT];
        default: ;
      endcase
    end
  end

  // One wait cycle per access; read data loaded while waitrequest is high
  always_ff @(posedge CLK) begin
    if (SRST)
      wait_r <= 1'b1;
    else
      wait_r <= !(req && wait_r);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_r <= '0;
    end else if (AVS_READ && wait_r) begin
      rdata_r <= '0;
      case (AVS_ADDRESS)
        ccp_pkg::OFS_SCC: begin
          rdata_r[ccp_pkg::SCC_SEL_LSB +: 3] <= sel_r;
          rdata_r[ccp_pkg::SCC_HS_KEEP]      <= hs_keep_r;
          rdata_r[ccp_pkg::SCC_LS_KEEP]      <= ls_keep_r;
        end
        ccp_pkg::OFS_FOSC: begin
          rdata_r[ccp_pkg::FOSC_EN_BIT] <= fosc_en_r;
          rdata_r[ccp_pkg::FOSC_STABLE] <= fast_osc.stable;
        end
        ccp_pkg::OFS_CTRL: rdata_r[ccp_pkg::CTRL_WDT_BIT] <= wdt_en_r;
        ccp_pkg::OFS_STATUS: begin
          rdata_r[2:0]                        <= mode_r;
          rdata_r[ccp_pkg::STAT_BUSY_BIT]     <= sw_busy;
          rdata_r[ccp_pkg::STAT_ACT_LSB +: 3] <= sel_act;
        end
        default: ;
      endcase
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign CPU_RUN         = cpu_run_r;
  assign SYS_TICK        = sys_tick_r;
  assign FAST_TICK       = fast_tick_r;
  assign SUB_TICK        = sub_tick_r;
  assign SLOW_OSC_TICK   = slow_rc_osc_tick_r;
endmodule
`default_nettype wire

// ===== rtl/ccp_pkg.sv
// Package: constants and types for the system clock and power-mode block
// Function
// - select codes 000-110 run CPU from divided fast clock; 111 from sub clock
// - code n divides fast clock by two to the n; 111 selects sub clock
// - fast clock comes from fast RC osc, sub clock from slow RC osc only
// - leaving fast for sub clock, fast osc runs or stops per its enable bit
// - FAST mode keeps CPU and all three clocks running; keep bits ignored
// - SLOW mode keeps sub and slow osc clocks; fast clock follows enable bit
// - halt with both keep bits 0 enters SLEEP: CPU, system, fast, sub stop
// - in SLEEP slow osc clock runs only when watchdog enabled
// - halt with keep 01 enters idle_low_only; system clock on only when 111
// - halt with keep 11 enters idle_both; all clocks on, CPU off
// - halt with keep 10 enters idle_high_only; sub off; sys on for 000-110
// - enabling fast osc clears stable flag, sets it once oscillator settles
// - source switch completes in 4 current periods plus source/target alignment
package ccp_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_SCC    = 4'h0;
  localparam logic [3:0] OFS_FOSC   = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Register field positions
  localparam int SCC_SEL_LSB    = 5;
  localparam int SCC_HS_KEEP    = 1;
  localparam int SCC_LS_KEEP    = 0;
  localparam int FOSC_EN_BIT    = 0;
  localparam int FOSC_STABLE    = 1;
  localparam int CTRL_WDT_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 3;
  localparam int STAT_ACT_LSB   = 4;
  // Reset values
  localparam logic [2:0] SEL_RESET   = 3'h2;
  localparam logic       FOSC_EN_RST = 1'b1;
  // Select encoding
  localparam logic [2:0] SEL_SUB     = 3'h7;
  localparam int         DIV_BITS    = 6;
  // Switch drain length in current system clock periods
  localparam logic [2:0] SWITCH_DRAIN = 3'h4;
  // Oscillator frequencies and core clock
  localparam longint CLK_HZ      = 125000000;
  localparam longint FAST_OSC_HZ = 20000000;
  localparam longint SLOW_OSC_HZ = 32000;
  localparam int FAST_TICK_DIV = int'(CLK_HZ / FAST_OSC_HZ);
  localparam int SLOW_TICK_DIV = int'(CLK_HZ / SLOW_OSC_HZ);
  // Fast oscillator settling time, least time rounds up
  localparam longint FAST_SETTLE_NS = 1000;
  localparam int FAST_SETTLE_CYC = int'((FAST_SETTLE_NS * CLK_HZ + 999999999) / 1000000000);
  localparam int SLOW_SETTLE_CYC = 1;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_IDLE_LOW,
    MODE_IDLE_BOTH,
    MODE_IDLE_HIGH
  } ccp_mode_t;
endpackage

// ===== rtl/ccp_osc_if.sv
// Interface: oscillator enable, tick and stable flag
`timescale 1ns/1ps
`default_nettype none
interface ccp_osc_if;
  logic en;
  logic tick;
  logic stable;
  modport src (input en, output tick, output stable);
  modport user (output en, input tick, input stable);
endinterface
`default_nettype wire

// ===== rtl/ccp_rc_osc.sv
// RC oscillator model: tick generator with settling flag
`timescale 1ns/1ps
`default_nettype none
module ccp_rc_osc #(
  parameter int TICK_DIV   = 6,
  parameter int SETTLE_CYC = 125
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Oscillator port
  ccp_osc_if.src    osc
);
  localparam int PW = $clog2(TICK_DIV + 1);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [PW-1:0] PER_LAST = PW'(TICK_DIV - 1);
  localparam logic [SW-1:0] SET_LAST = SW'(SETTLE_CYC);

  logic [PW-1:0] ph_r;
  logic [SW-1:0] settle_r;
  logic          tick_r;
  logic          stable_r;

  // Phase counter runs only while enabled so a stopped osc gives no ticks
  always_ff @(posedge clk) begin
    if (srst || !osc.en) begin
      ph_r   <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (ph_r == PER_LAST) && stable_r;
      ph_r   <= (ph_r == PER_LAST) ? '0 : ph_r + 1'b1;
    end
  end

  // Flag drops with the enable and rises after settling
  always_ff @(posedge clk) begin
    if (srst || !osc.en) begin
      settle_r <= '0;
      stable_r <= 1'b0;
    end else if (settle_r != SET_LAST) begin
      settle_r <= settle_r + 1'b1;
    end else begin
      stable_r <= 1'b1;
    end
  end

  assign osc.tick   = tick_r;
  assign osc.stable = stable_r;
endmodule
`default_nettype wire

// ===== rtl/ccp_clk_switch.sv
// Glitch-free system clock source switch on tick boundaries
`timescale 1ns/1ps
`default_nettype none
module ccp_clk_switch (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Requested select and candidate ticks
  input  wire logic [2:0] sel_req,
  input  wire logic [7:0] src_tick,
  // Results
  output logic            sys_tick,
  output logic [2:0]      sel_act,
  output logic            busy
);
  typedef enum logic [1:0] {SW_STEADY, SW_DRAIN, SW_ALIGN} ccp_sw_t;

  ccp_sw_t    st_r;
  logic [2:0] act_r;
  logic [2:0] tgt_r;
  logic [2:0] cnt_r;
  logic       cur_tick;
  logic       tgt_tick;

  assign cur_tick = src_tick[act_r];
  assign tgt_tick = src_tick[tgt_r];

  // Drain whole current periods, then hand over on a target tick
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r  <= SW_STEADY;
      act_r <= ccp_pkg::SEL_RESET;
      tgt_r <= ccp_pkg::SEL_RESET;
      cnt_r <= '0;
    end else if (sel_req != tgt_r && sel_req != act_r) begin
      st_r  <= SW_DRAIN;
      tgt_r <= sel_req;
      cnt_r <= '0;
    end else begin
      case (st_r)
        SW_STEADY: begin
          tgt_r <= act_r;
          if (sel_req != act_r) begin
            st_r  <= SW_DRAIN;
            tgt_r <= sel_req;
            cnt_r <= '0;
          end
        end
        SW_DRAIN: begin
          if (sel_req == act_r) begin
            st_r  <= SW_STEADY;
            tgt_r <= act_r;
          end else if (cur_tick) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r + 1'b1 == ccp_pkg::SWITCH_DRAIN)
              st_r <= SW_ALIGN;
          end
        end
        SW_ALIGN: begin
          // Change only at a target edge so no short pulse appears
          if (tgt_tick) begin
            act_r <= tgt_r;
            st_r  <= SW_STEADY;
          end
        end
        default: st_r <= SW_STEADY;
      endcase
    end
  end

  // Parked during alignment; the handover tick is swallowed, since it may
  // land just after the last old tick and would make a short period
  assign sys_tick = (st_r == SW_ALIGN) ? 1'b0 : cur_tick;
  assign sel_act  = act_r;
  assign busy     = (st_r != SW_STEADY);
endmodule
`default_nettype wire

// ===== dv/ccp_props.sv
// Checker: bus timing, power-mode clock gating and glitch spacing
`timescale 1ns/1ps
`default_nettype none
module ccp_props #(
  parameter int FAST_DIV    = 6,
  parameter int SLOW_DIV    = 8,
  parameter int FAST_SETTLE = 4
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Bus
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  // Power control and ticks
  input wire logic        HALT,
  input wire logic        WAKE,
  input wire logic        CPU_RUN,
  input wire logic        SYS_TICK,
  input wire logic        FAST_TICK,
  input wire logic        SUB_TICK,
  input wire logic        SLOW_OSC_TICK
);
  localparam int FW = FAST_DIV + 1;
  logic [1:0] keep_r;
  logic       wdt_r;
  logic [9:0] gap_r;
  logic       seen_r;
  logic       wr_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  always_ff @(posedge CLK) begin
    if (SRST) keep_r <= 2'h0;
    else if (wr_ok && AVS_ADDRESS == 4'h0) keep_r <= AVS_WRITEDATA[1:0];
  end
  always_ff @(posedge CLK) begin
    if (SRST) wdt_r <= 1'b0;
    else if (wr_ok && AVS_ADDRESS == 4'h8) wdt_r <= AVS_WRITEDATA[0];
  end
  // Saturating gap so a long stop cannot wrap into a short one
  always_ff @(posedge CLK) begin
    if (SRST || SYS_TICK) gap_r <= 10'h0;
    else if (gap_r != 10'h3ff) gap_r <= gap_r + 10'h1;
  end
  always_ff @(posedge CLK) begin
    if (SRST) seen_r <= 1'b0;
    else if (SYS_TICK) seen_r <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Off long enough for the registered tick lag to have passed
  sequence s_off;
    (!CPU_RUN && !WAKE)[*4];
  endsequence
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  property p_wait_once;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  property p_halt;
    HALT && CPU_RUN && !WAKE |-> ##[1:3] !CPU_RUN;
  endproperty
  property p_sleep;
    s_off ##0 keep_r == 2'h0 |-> !SYS_TICK && !FAST_TICK && !SUB_TICK;
  endproperty
  property p_sleep_wdt;
    s_off ##0 (keep_r == 2'h0 && !wdt_r) |-> !SLOW_OSC_TICK;
  endproperty
  property p_idle_low;
    s_off ##0 keep_r == 2'h1 |-> !FAST_TICK;
  endproperty
  property p_idle_both;
    s_off ##0 keep_r == 2'h3 |-> ##[0:FW] FAST_TICK;
  endproperty
  property p_idle_high;
    s_off ##0 keep_r == 2'h2 |-> !SUB_TICK;
  endproperty
  property p_glitch;
    SYS_TICK && seen_r |-> gap_r >= 10'(FAST_DIV - 1);
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest not low after request");
  a_wait_once: assert property (p_wait_once) else $error("waitrequest low too long");
  a_halt: assert property (p_halt) else $error("halt did not stop cpu");
  a_sleep: assert property (p_sleep) else $error("clock running in sleep");
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("slow osc tick in sleep");
  a_idle_low: assert property (p_idle_low) else $error("fast tick in idle low");
  a_idle_both: assert property (p_idle_both) else $error("fast tick lost in idle");
  a_idle_high: assert property (p_idle_high) else $error("sub tick in idle high");
  a_glitch: assert property (p_glitch) else $error("system tick too close");
endmodule
bind ccp_clock_ctrl ccp_props #(
  .FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV), .FAST_SETTLE(FAST_SETTLE)) u_props (.*);
`default_nettype wire

// ===== dv/ccp_cpu_model.sv
// CPU core model: turns bench requests into halt and wake pulses
`timescale 1ns/1ps
`default_nettype none
module ccp_cpu_model (
  // Clock
  input  wire logic clk,
  // Bench requests and core state
  input  wire logic halt_req,
  input  wire logic wake_req,
  input  wire logic cpu_run,
  // Power control
  output logic      halt,
  output logic      wake
);
  initial begin
    halt = 1'b0;
    wake = 1'b0;
  end
  // A halt is an instruction, so only a running core issues it
  always @(posedge clk) halt <= halt_req && cpu_run && !halt;
  always @(posedge clk) wake <= wake_req && !cpu_run && !wake;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench: registers, clock select, switch timing and power modes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int FD = 6;
  localparam int SD = 8;
  localparam int FS = 4;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST, HALT, WAKE, CPU_RUN;
  logic        SYS_TICK, FAST_TICK, SUB_TICK, SLOW_OSC_TICK;
  logic        halt_req = 1'b0;
  logic        wake_req = 1'b0;
  logic [3:0]  be_v = 4'hf;
  logic [3:0]  tv;
  logic [31:0] rdata;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          cnt[4];
  assign tv = {SLOW_OSC_TICK, SUB_TICK, FAST_TICK, SYS_TICK};
  ccp_clock_ctrl #(.FAST_DIV(FD), .SLOW_DIV(SD), .FAST_SETTLE(FS)) dut (.*);
  ccp_cpu_model cpu (.clk(CLK), .halt_req(halt_req), .wake_req(wake_req),
                     .cpu_run(CPU_RUN), .halt(HALT), .wake(WAKE));
  initial forever #4 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Read results are judged here against the oldest note
  always @(posedge CLK) begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) check(AVS_READDATA, e[31:0]);
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     input logic [32:0] x);
    @(posedge CLK);
    if (!w) exp_q.push_back(x);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= v;
    AVS_BYTEENABLE <= be_v;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rdata = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 33'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v);
    bus(1'b0, a, 32'h0, {1'b1, v});
  endtask
  task automatic settle(input int cur, input int tgt);
    int t0;
    t0 = cyc;
    do bus(1'b0, 4'hc, 32'h0, 33'h0); while (rdata[3] !== 1'b0);
    check(32'(cyc - t0 <= 6 * cur + 2 * tgt + 12), 32'h1);
  endtask
  task automatic period(output int p);
    int t0;
    do @(posedge CLK); while (SYS_TICK !== 1'b1);
    t0 = cyc;
    do @(posedge CLK); while (SYS_TICK !== 1'b1);
    p = cyc - t0;
  endtask
  task automatic count(input int n);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (n) begin
      @(posedge CLK);
      for (int i = 0; i < 4; i++) cnt[i] += int'(tv[i] === 1'b1);
    end
  endtask
  initial begin
    int p, pe, pc, m;
    logic [1:0] k;
    logic [2:0] s;
    logic w, sy;
    void'($urandom(32'h4a36));
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    wr(4'h1, 32'hff);
    rd(4'h0, 32'h40);
    rd(4'hc, 32'h20);
    rd(4'h2, 32'h0);
    be_v = 4'he;
    wr(4'h8, 32'h1);
    be_v = 4'hf;
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h3);
    pc = FD << 2;
    for (int n = 0; n < 8; n++) begin
      k = 2'($urandom);
      pe = (n < 7) ? FD << n : SD;
      wr(4'h0, {24'($urandom), 3'(n), 3'($urandom), k});
      settle(pc, pe);
      rd(4'h0, {24'h0, 3'(n), 3'h0, k});
      rd(4'hc, {25'h0, 3'(n), 4'h0});
      period(p);
      check(32'(p), 32'(pe));
      count(2 * SD + 2);
      check(32'(cnt[1] > 0 && cnt[2] > 0 && cnt[3] > 0), 32'h1);
      pc = pe;
    end
    wr(4'h4, 32'h0);
    rd(4'h4, 32'h0);
    count(3 * FD);
    check(32'(cnt[1]), 32'h0);
    check(32'(cnt[0] > 0 && cnt[2] > 0), 32'h1);
    wr(4'h4, 32'h1);
    rd(4'h4, 32'h1);
    count(FS + 4);
    rd(4'h4, 32'h3);
    for (int c = 0; c < 8; c++) begin
      k = 2'(c);
      s = c[2] ? 3'h7 : 3'h0;
      w = 1'($urandom);
      pe = c[2] ? SD : FD;
      wr(4'h8, 32'(w));
      wr(4'h0, {24'h0, s, 3'h0, k});
      settle(pc, pe);
      pc = pe;
      halt_req <= 1'b1;
      @(posedge CLK);
      halt_req <= 1'b0;
      count(8);
      count(4 * SD);
      sy = k == 2'h3 || (k == 2'h1 && s == 3'h7) || (k == 2'h2 && s != 3'h7);
      m = (k == 2'h2) ? 4 : (k == 2'h3) ? 3 : k + 1;
      check(32'({cnt[3] > 0, cnt[2] > 0, cnt[1] > 0, cnt[0] > 0}),
            32'({k != 2'h0 || w, k[0], k[1], sy}));
      rd(4'hc, {25'h0, s, 1'b0, 3'(m)});
      wake_req <= 1'b1;
      @(posedge CLK);
      wake_req <= 1'b0;
      count(6);
    end
    summarize();
  end
  initial begin
    #(8 * 40000);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
